// ==== design/config_regs_defines.svh ====
// Register indices, field positions, write masks and reset values
// Assumes inclusion by bare name from the design files
`ifndef CONFIG_REGS_DEFINES_SVH
`define CONFIG_REGS_DEFINES_SVH

// ==========================================
// Register indices
`define IDX_DECODER_ADDR_LOW       8'h08
`define IDX_DECODER_ADDR_HIGH_CFG  8'h09
`define IDX_IR_MUX_FIFO_THRESHOLD  8'h0A
`define IDX_DRIVE_RATE_SELECT      8'h0B
`define IDX_SERIAL_MODE_CONTROL    8'h0C
`define IDX_DEVICE_IDENTITY        8'h0D
`define IDX_SILICON_REVISION       8'h0E
`define IDX_TEST_CONTROL_A         8'h0F
`define IDX_TEST_CONTROL_B         8'h10

// ==========================================
// Reset values
`define RST_DECODER_ADDR_LOW       8'h00
`define RST_DECODER_ADDR_HIGH_CFG  8'h00
`define RST_IR_MUX_FIFO_THRESHOLD  8'h00
`define RST_DRIVE_RATE_SELECT      8'h00
`define RST_SERIAL_MODE_CONTROL    8'h02
`define RST_TEST_CONTROL           8'h00

// ==========================================
// Writable bits; the rest are reserved and read zero
`define WMASK_DECODER_ADDR_LOW     8'hF0
`define WMASK_DECODER_ADDR_HIGH    8'hCF
`define WMASK_IR_MUX_FIFO          8'hCF

// ==========================================
// Field positions
`define POS_DEC_LOW_NIBBLE         4
`define POS_DEC_CFG                6
`define POS_IR_MUX                 6
`define POS_HIGH_ADDR_ZERO         12

`endif

// ==== design/config_regs_pkg.sv ====
// Types shared by the configuration register bank
// Assumes config_regs_defines.svh carries all numeric constants
package config_regs_pkg;

  // Host access strobes, one cycle each, on the clk domain
  typedef struct packed {
    logic       idx_wr;
    logic       dat_wr;
    logic       dat_rd;
    logic [7:0] wdata;
  } host_req_t;

  typedef enum logic [1:0] {
    DEC_OFF  = 2'b00,
    DEC_1B   = 2'b01,
    DEC_8B   = 2'b10,
    DEC_16B  = 2'b11
  } dec_size_t;

  typedef enum logic [1:0] {
    IR_FIRST  = 2'b00,
    IR_SECOND = 2'b01,
    IR_RSVD   = 2'b10,
    IR_OFF    = 2'b11
  } ir_mux_t;

  typedef enum logic [2:0] {
    MODE_STANDARD = 3'b000,
    MODE_PULSE_IR = 3'b001,
    MODE_ASK_IR   = 3'b010
  } serial2_mode_t;

  typedef struct packed {
    logic          uart2_high_speed;
    logic          uart1_high_speed;
    serial2_mode_t uart2_mode;
    logic          uart2_half_duplex;
    logic          uart2_tx_active_low;
    logic          uart2_rx_active_low;
  } serial_mode_t;

endpackage

// ==== design/config_index_port.sv ====
// Index register and access qualification for the configuration bank
// Assumes strobes are synchronous to clk and config_state is a clean level
`timescale 1ns/1ns
module config_index_port (
  input  wire logic                    clk,          // System clock
  input  wire logic                    srst,         // Sync reset, high
  input  wire logic                    config_state, // Device in config state
  input  wire config_regs_pkg::host_req_t host_req,  // Host strobes and data
  output logic [7:0]                   cfg_index,    // Current index
  output logic                         reg_wr,       // Qualified data write
  output logic                         reg_rd        // Qualified data read
);
  import config_regs_pkg::*;

  // ==========================================
  // Index register, loaded only in configuration state
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_index <= 8'h00;
    end else if (config_state && host_req.idx_wr) begin
      cfg_index <= host_req.wdata;
    end
  end

  // Outside configuration state data accesses do nothing
  assign reg_wr = config_state & host_req.dat_wr;
  assign reg_rd = config_state & host_req.dat_rd;

endmodule

// ==== design/addr_decoder.sv ====
// General address decoder window match
// Assumes host_addr is stable while the select is in use
`timescale 1ns/1ns
`include "config_regs_defines.svh"
module addr_decoder (
  input  wire logic [15:0]              host_addr,  // Host I/O address
  input  wire logic [7:0]               base_addr,  // Programmed A11:A4
  input  wire config_regs_pkg::dec_size_t size,     // Window size
  output logic                          hit         // Window match
);
  import config_regs_pkg::*;

  wire upper_zero = (host_addr[15:`POS_HIGH_ADDR_ZERO] == 4'h0);
  wire base_eq    = (host_addr[11:4] == base_addr);
  logic low_ok;

  // Size picks how many low address bits must be zero
  always_comb begin
    case (size)
      DEC_1B:  low_ok = (host_addr[3:0] == 4'h0);
      DEC_8B:  low_ok = ~host_addr[3];
      DEC_16B: low_ok = 1'b1;
      default: low_ok = 1'b0;
    endcase
  end

  assign hit = upper_zero & base_eq & low_ok;

endmodule

// ==== design/config_regs_addr_decoder.sv ====
// Configuration registers 08h..10h with address decoder and IR pin mux
// Assumes host strobes on clk; IR receive pins are asynchronous
`timescale 1ns/1ns
`include "config_regs_defines.svh"
module config_regs_addr_decoder #(
  parameter logic [7:0] DEVICE_ID = 8'h5A,  // Arbitrary identification value
  parameter logic [7:0] REVISION  = 8'h00   // Silicon revision level
) (
  input  wire logic                      clk,                     // System clock
  input  wire logic                      srst,                    // Sync reset, high
  input  wire logic                      config_state,            // Config state level
  input  wire config_regs_pkg::host_req_t host_req,               // Host strobes
  input  wire logic [15:0]               host_addr,               // Host I/O address
  output logic [7:0]                     host_rdata,              // Read data
  output logic                           decoder_select_n,        // Decoder select, low
  output logic [3:0]                     fifo_threshold,          // ECP FIFO threshold
  output logic [7:0]                     rate_table_select,       // Per-drive rate table
  output config_regs_pkg::serial_mode_t  serial_mode,             // Serial mode fields
  output logic [7:0]                     test_control_a,          // Test register A
  output logic [7:0]                     test_control_b,          // Test register B
  input  wire logic                      uart2_tx,                // Second port transmit
  output logic                           uart2_rx,                // Second port receive
  input  wire logic                      ir_receive_first,        // First IR receive pin
  input  wire logic                      ir_receive_second,       // Second IR receive pin
  output logic                           ir_transmit_first,       // First IR transmit
  output logic                           ir_transmit_first_oe_n,  // Low while driving
  output logic                           ir_transmit_second,      // Second IR transmit
  output logic                           ir_transmit_second_oe_n  // Low while driving
);
  import config_regs_pkg::*;

  // ==========================================
  // Write-mask merge, used for every masked register
  function automatic logic [7:0] masked(input logic [7:0] wdata, input logic [7:0] wmask);
    masked = wdata & wmask;
  endfunction

  // ==========================================
  // Index port
  logic [7:0] cfg_index;
  logic       reg_wr;
  logic       reg_rd;

  config_index_port u_index (
    .clk          (clk),
    .srst         (srst),
    .config_state (config_state),
    .host_req     (host_req),
    .cfg_index    (cfg_index),
    .reg_wr       (reg_wr),
    .reg_rd       (reg_rd)
  );

  // ==========================================
  // Index decode
  wire sel_dec_low  = (cfg_index == `IDX_DECODER_ADDR_LOW);
  wire sel_dec_high = (cfg_index == `IDX_DECODER_ADDR_HIGH_CFG);
  wire sel_fifo     = (cfg_index == `IDX_IR_MUX_FIFO_THRESHOLD);
  wire sel_rate     = (cfg_index == `IDX_DRIVE_RATE_SELECT);
  wire sel_serial   = (cfg_index == `IDX_SERIAL_MODE_CONTROL);
  wire sel_test_a   = (cfg_index == `IDX_TEST_CONTROL_A);
  wire sel_test_b   = (cfg_index == `IDX_TEST_CONTROL_B);

  wire wr_dec_low   = reg_wr & sel_dec_low;
  wire wr_dec_high  = reg_wr & sel_dec_high;
  wire wr_fifo      = reg_wr & sel_fifo;
  wire wr_rate      = reg_wr & sel_rate;
  wire wr_serial    = reg_wr & sel_serial;
  wire wr_test_a    = reg_wr & sel_test_a;
  wire wr_test_b    = reg_wr & sel_test_b;

  // ==========================================
  // Register storage
  logic [7:0] decoder_addr_low;
  logic [7:0] decoder_addr_high_cfg;
  logic [7:0] ir_mux_fifo_threshold;
  logic [7:0] drive_rate_select;
  logic [7:0] serial_mode_control;

  // Reserved bits never store, so they read back zero
  always_ff @(posedge clk) begin
    if (srst) begin
      decoder_addr_low <= `RST_DECODER_ADDR_LOW;
    end else if (wr_dec_low) begin
      decoder_addr_low <= masked(host_req.wdata, `WMASK_DECODER_ADDR_LOW);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      decoder_addr_high_cfg <= `RST_DECODER_ADDR_HIGH_CFG;
    end else if (wr_dec_high) begin
      decoder_addr_high_cfg <= masked(host_req.wdata, `WMASK_DECODER_ADDR_HIGH);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ir_mux_fifo_threshold <= `RST_IR_MUX_FIFO_THRESHOLD;
    end else if (wr_fifo) begin
      ir_mux_fifo_threshold <= masked(host_req.wdata, `WMASK_IR_MUX_FIFO);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      drive_rate_select <= `RST_DRIVE_RATE_SELECT;
    end else if (wr_rate) begin
      drive_rate_select <= host_req.wdata;
    end
  end

  // Reserved mode codes are stored as written; the port treats them as its own
  always_ff @(posedge clk) begin
    if (srst) begin
      serial_mode_control <= `RST_SERIAL_MODE_CONTROL;
    end else if (wr_serial) begin
      serial_mode_control <= host_req.wdata;
    end
  end

  // Test registers hold what is written; nothing inside acts on them
  always_ff @(posedge clk) begin
    if (srst) begin
      test_control_a <= `RST_TEST_CONTROL;
      test_control_b <= `RST_TEST_CONTROL;
    end else begin
      if (wr_test_a) begin
        test_control_a <= host_req.wdata;
      end
      if (wr_test_b) begin
        test_control_b <= host_req.wdata;
      end
    end
  end

  // ==========================================
  // Field views
  wire [3:0] decode_addr_low_nibble  = decoder_addr_low[7:`POS_DEC_LOW_NIBBLE];
  wire [3:0] decode_addr_high_nibble = decoder_addr_high_cfg[3:0];
  wire [1:0] dec_cfg_bits            = decoder_addr_high_cfg[7:`POS_DEC_CFG];
  wire [1:0] ir_mux_bits             = ir_mux_fifo_threshold[7:`POS_IR_MUX];
  wire       fifo_threshold_bit      = ir_mux_fifo_threshold[0];

  dec_size_t dec_size;
  ir_mux_t   ir_mux;
  assign dec_size = dec_size_t'(dec_cfg_bits);
  assign ir_mux   = ir_mux_t'(ir_mux_bits);

  // ==========================================
  // Plain field outputs, each straight from its register
  assign fifo_threshold    = {ir_mux_fifo_threshold[3:1], fifo_threshold_bit};
  assign rate_table_select = drive_rate_select;
  assign serial_mode       = serial_mode_t'(serial_mode_control);

  // ==========================================
  // General address decoder
  logic dec_hit;

  addr_decoder u_decoder (
    .host_addr (host_addr),
    .base_addr ({decode_addr_high_nibble, decode_addr_low_nibble}),
    .size      (dec_size),
    .hit       (dec_hit)
  );

  // Combinational on purpose: a registered select would miss short I/O cycles
  assign decoder_select_n = ~dec_hit;

  // ==========================================
  // Read path, one cycle after the read strobe
  logic [7:0] read_value;

  always_comb begin
    case (cfg_index)
      `IDX_DECODER_ADDR_LOW:      read_value = decoder_addr_low;
      `IDX_DECODER_ADDR_HIGH_CFG: read_value = decoder_addr_high_cfg;
      `IDX_IR_MUX_FIFO_THRESHOLD: read_value = ir_mux_fifo_threshold;
      `IDX_DRIVE_RATE_SELECT:     read_value = drive_rate_select;
      `IDX_SERIAL_MODE_CONTROL:   read_value = serial_mode_control;
      `IDX_DEVICE_IDENTITY:       read_value = DEVICE_ID;
      `IDX_SILICON_REVISION:      read_value = REVISION;
      `IDX_TEST_CONTROL_A:        read_value = test_control_a;
      `IDX_TEST_CONTROL_B:        read_value = test_control_b;
      default:                    read_value = 8'h00;
    endcase
  end

  // Last read value holds until the next qualified read
  always_ff @(posedge clk) begin
    if (srst) begin
      host_rdata <= 8'h00;
    end else if (reg_rd) begin
      host_rdata <= read_value;
    end
  end

  // ==========================================
  // IR receive pin synchronisers
  logic [1:0] rx_meta;
  logic [1:0] rx_sync;
  wire  [1:0] rx_pins = {ir_receive_second, ir_receive_first};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_rx_sync
      always_ff @(posedge clk) begin
        if (srst) begin
          rx_meta[g] <= 1'b0;
          rx_sync[g] <= 1'b0;
        end else begin
          rx_meta[g] <= rx_pins[g];
          rx_sync[g] <= rx_meta[g];
        end
      end
    end
  endgenerate

  // ==========================================
  // IR pin routing
  // Reserved mux code is treated as off so no pin is driven by surprise
  wire use_first  = (ir_mux == IR_FIRST);
  wire use_second = (ir_mux == IR_SECOND);

  // Polarity is applied here so the port core stays polarity free
  wire rx_routed  = use_second ? rx_sync[1] : rx_sync[0];
  wire next_rx    = rx_routed ^ serial_mode_control[0];
  wire next_tx    = uart2_tx ^ serial_mode_control[1];
  // Half duplex blanks receive while the transmitter is active
  wire tx_active  = next_tx ^ serial_mode_control[1];
  wire rx_blank   = serial_mode_control[2] & tx_active;
  wire rx_idle    = serial_mode_control[0];

  always_ff @(posedge clk) begin
    if (srst) begin
      uart2_rx                <= 1'b0;
      ir_transmit_first       <= 1'b0;
      ir_transmit_second      <= 1'b0;
      ir_transmit_first_oe_n  <= 1'b1;
      ir_transmit_second_oe_n <= 1'b1;
    end else begin
      uart2_rx                <= rx_blank ? ~rx_idle : next_rx;
      ir_transmit_first       <= next_tx;
      ir_transmit_second      <= next_tx;
      ir_transmit_first_oe_n  <= ~use_first;
      ir_transmit_second_oe_n <= ~use_second;
    end
  end

endmodule

// ==== sim/config_regs_addr_decoder_asserts.sv ====
// Concurrent checks on the configuration bank's top-level ports
// Assumes one clock domain and binding into config_regs_addr_decoder
`timescale 1ns/1ns
module config_regs_checker #(
  parameter logic [7:0] DEVICE_ID = 8'h5A,
  parameter logic [7:0] REVISION  = 8'h00
) (
  input wire logic                          clk,                     // System clock
  input wire logic                          srst,                    // Sync reset
  input wire logic                          config_state,            // Config state
  input wire config_regs_pkg::host_req_t    host_req,                // Host strobes
  input wire logic [15:0]                   host_addr,               // Host address
  input wire logic [7:0]                    host_rdata,              // Read data
  input wire logic                          decoder_select_n,        // Decoder select
  input wire logic [3:0]                    fifo_threshold,          // Threshold
  input wire logic [7:0]                    rate_table_select,       // Drive rates
  input wire config_regs_pkg::serial_mode_t serial_mode,             // Serial mode
  input wire logic [7:0]                    test_control_a,          // Test reg A
  input wire logic                          uart2_tx,                // Core transmit
  input wire logic                          ir_transmit_first,       // First tx pin
  input wire logic                          ir_transmit_first_oe_n,  // First enable
  input wire logic                          ir_transmit_second_oe_n  // Second enable
);
  import config_regs_pkg::*;
  logic [7:0] idx;
  // ==========================================
  // Index shadow, so reads can be tied to what they address
  always_ff @(posedge clk) begin
    if (srst)
      idx <= 8'h00;
    else if (host_req.idx_wr && config_state)
      idx <= host_req.wdata;
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_no_idle_write: assert property (!config_state |=> $stable(rate_table_select) &&
    $stable(serial_mode) && $stable(fifo_threshold) && $stable(test_control_a))
    else $error("register changed outside config state");
  a_reset_values: assert property (disable iff (1'b0) srst |=> serial_mode == 8'h02 &&
    fifo_threshold == 4'h0 && rate_table_select == 8'h00 && test_control_a == 8'h00 && decoder_select_n)
    else $error("wrong value after reset");
  a_mux_default: assert property (disable iff (1'b0) srst ##1 !srst |=>
    !ir_transmit_first_oe_n && ir_transmit_second_oe_n) else $error("ir mux not at default after reset");
  a_select_top: assert property (!decoder_select_n |-> host_addr[15:12] == 4'h0)
    else $error("select with upper address bits set");
  a_select_cause: assert property ($changed(decoder_select_n) |->
    $changed(host_addr) || $past(host_req.dat_wr) || $past(srst)) else $error("select moved without cause");
  a_tx_follow: assert property (!$past(srst) && !ir_transmit_first_oe_n |->
    ir_transmit_first == ($past(uart2_tx) ^ $past(serial_mode.uart2_tx_active_low)))
    else $error("transmit pin not following core");
  a_oe_exclusive: assert property (ir_transmit_first_oe_n || ir_transmit_second_oe_n)
    else $error("both transmit pins driven");
  a_rdata_hold: assert property ($changed(host_rdata) |->
    $past(host_req.dat_rd && config_state) || $past(srst)) else $error("read data moved without read");
  a_id_read: assert property (host_req.dat_rd && config_state && idx == 8'h0D |->
    ##[1:2] host_rdata == DEVICE_ID) else $error("wrong identification read");
  a_rev_read: assert property (host_req.dat_rd && config_state && idx == 8'h0E |->
    ##[1:2] host_rdata == REVISION) else $error("wrong revision read");
endmodule

bind config_regs_addr_decoder config_regs_checker #(.DEVICE_ID(DEVICE_ID), .REVISION(REVISION)) chk (
  .clk(clk), .srst(srst), .config_state(config_state), .host_req(host_req), .host_addr(host_addr),
  .host_rdata(host_rdata), .decoder_select_n(decoder_select_n), .fifo_threshold(fifo_threshold),
  .rate_table_select(rate_table_select), .serial_mode(serial_mode), .test_control_a(test_control_a),
  .uart2_tx(uart2_tx), .ir_transmit_first(ir_transmit_first),
  .ir_transmit_first_oe_n(ir_transmit_first_oe_n), .ir_transmit_second_oe_n(ir_transmit_second_oe_n));

// ==== sim/host_model.sv ====
// Host processor model driving the index/data configuration port
// Assumes the bank samples strobes on the rising clock edge
`timescale 1ns/1ns
module host_model (
  input  wire logic                   clk,          // System clock
  input  wire logic [7:0]             host_rdata,   // Read data from the bank
  output config_regs_pkg::host_req_t  host_req,     // Strobes and data
  output logic                        config_state  // Config state level
);
  import config_regs_pkg::*;
  initial begin
    host_req     = '0;
    config_state = 1'b0;
  end
  task automatic set_cfg(input logic v);
    @(negedge clk);
    config_state = v;
  endtask
  // Kind 0 index, 1 data write, 2 data read; one cycle each
  task automatic strobe(input int kind, input logic [7:0] data);
    @(negedge clk);
    host_req.wdata  = data;
    host_req.idx_wr = (kind == 0);
    host_req.dat_wr = (kind == 1);
    host_req.dat_rd = (kind == 2);
    @(negedge clk);
    host_req.idx_wr = 1'b0;
    host_req.dat_wr = 1'b0;
    host_req.dat_rd = 1'b0;
    // Released bus must not look like the last byte
    host_req.wdata  = ~data;
  endtask
  // Index always loaded first; test registers are never written
  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] data);
    strobe(0, idx);
    strobe(1, data);
  endtask
  task automatic rd_reg(input logic [7:0] idx, output logic [7:0] data);
    strobe(0, idx);
    strobe(2, 8'h00);
    @(negedge clk);
    data = host_rdata;
  endtask
endmodule

// ==== sim/config_regs_addr_decoder_tb_top.sv ====
// Self-checking bench for the configuration bank
// Assumes host_model as the host and the bound checker
`timescale 1ns/1ns
module config_regs_addr_decoder_tb_top;
  import config_regs_pkg::*;
  localparam logic [7:0] ID_VAL  = 8'hA5;  // Arbitrary value
  localparam logic [7:0] REV_VAL = 8'h03;
  logic clk = 1'b0, srst = 1'b1, uart2_tx = 1'b0, ir_rx1 = 1'b1, ir_rx2 = 1'b1;
  logic [15:0] host_addr = 16'h0000;
  logic [7:0] host_rdata, rate_table_select, test_a, test_b, rd;
  logic [3:0] fifo_threshold;
  logic config_state, sel_n, uart2_rx, tx1, tx1_oe_n, tx2, tx2_oe_n;
  host_req_t host_req;
  serial_mode_t serial_mode;
  int errors = 0;
  int n_compared = 0;
  logic [7:0] rst_exp [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, ID_VAL, REV_VAL, 8'h00, 8'h00};
  logic [7:0] wr_exp [7] = '{8'hF0, 8'hCF, 8'hCF, 8'hFF, 8'hFF, ID_VAL, REV_VAL};
  logic [15:0] probes [7] = '{16'h0230, 16'h0231, 16'h0238, 16'h023F, 16'h0240, 16'h0330, 16'h1230};
  always #50 clk = ~clk;
  host_model host (.clk(clk), .host_rdata(host_rdata), .host_req(host_req), .config_state(config_state));
  config_regs_addr_decoder #(.DEVICE_ID(ID_VAL), .REVISION(REV_VAL)) uut (
    .clk(clk), .srst(srst), .config_state(config_state), .host_req(host_req), .host_addr(host_addr),
    .host_rdata(host_rdata), .decoder_select_n(sel_n), .fifo_threshold(fifo_threshold),
    .rate_table_select(rate_table_select), .serial_mode(serial_mode), .test_control_a(test_a),
    .test_control_b(test_b), .uart2_tx(uart2_tx), .uart2_rx(uart2_rx), .ir_receive_first(ir_rx1),
    .ir_receive_second(ir_rx2), .ir_transmit_first(tx1), .ir_transmit_first_oe_n(tx1_oe_n),
    .ir_transmit_second(tx2), .ir_transmit_second_oe_n(tx2_oe_n));
  // ==========================================
  // Checking helpers
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    chk8(what, {7'h00, exp}, {7'h00, got});
  endtask
  task automatic close_out;
    if (errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic do_reset;
    @(negedge clk);
    srst = 1'b1;
    repeat (8) @(negedge clk);
    srst = 1'b0;
  endtask
  function automatic logic exp_sel_n(input logic [1:0] code, input logic [15:0] a);
    logic hit;
    hit = (a[15:4] == 12'h023);
    case (code)
      2'b01: return !(hit && a[3:0] == 4'h0);
      2'b10: return !(hit && !a[3]);
      2'b11: return !hit;
      default: return 1'b1;
    endcase
  endfunction
  // ==========================================
  // Tests
  initial begin
    #500000;
    errors++;
    close_out();
  end
  initial begin
    do_reset();
    host.set_cfg(1'b1);
    for (int i = 8; i <= 17; i++) begin
      host.rd_reg(i[7:0], rd);
      chk8("reset read", (i < 17) ? rst_exp[i-8] : 8'h00, rd);
    end
    chk8("test_control_a", 8'h00, test_a);
    chk8("test_control_b", 8'h00, test_b);
    // Index 0D and 0E written too: must stay read-only
    for (int i = 8; i <= 14; i++)
      host.wr_reg(i[7:0], 8'hFF);
    for (int i = 8; i <= 14; i++) begin
      host.rd_reg(i[7:0], rd);
      chk8("write read", wr_exp[i-8], rd);
    end
    chk8("rate_table_select", 8'hFF, rate_table_select);
    chk8("fifo_threshold", 8'h0F, {4'h0, fifo_threshold});
    chk8("serial_mode", 8'hFF, serial_mode);
    host.set_cfg(1'b0);
    host.wr_reg(8'h0B, 8'h00);
    // Index load and read both refused: read data keeps the last revision read
    host.rd_reg(8'h0B, rd);
    chk8("read outside config", REV_VAL, rd);
    host.set_cfg(1'b1);
    chk8("rate_table_select", 8'hFF, rate_table_select);
    for (int k = 0; k < 3; k++) begin
      host.wr_reg(8'h0C, {2'b10, k[2:0], 3'b000});
      chk8("serial_mode", {2'b10, k[2:0], 3'b000}, serial_mode);
    end
    host.wr_reg(8'h08, 8'h30);
    for (int c = 0; c < 4; c++) begin
      host.wr_reg(8'h09, {c[1:0], 2'b11, 4'h2});
      foreach (probes[i]) begin
        @(negedge clk);
        host_addr = probes[i];
        #1 chk1("decoder_select_n", exp_sel_n(c[1:0], probes[i]), sel_n);
      end
    end
    host.rd_reg(8'h09, rd);
    chk8("decoder high", 8'hC2, rd);
    for (int m = 0; m < 4; m++) begin
      host.wr_reg(8'h0A, {m[1:0], 6'h05});
      repeat (2) @(negedge clk);
      chk1("first_oe_n", m != 0, tx1_oe_n);
      chk1("second_oe_n", m != 1, tx2_oe_n);
      chk8("fifo_threshold", 8'h05, {4'h0, fifo_threshold});
    end
    host.wr_reg(8'h0A, 8'h00);
    host.wr_reg(8'h0C, 8'h00);
    uart2_tx = 1'b1;
    ir_rx1 = 1'b0;
    repeat (4) @(negedge clk);
    chk1("ir_transmit_first", 1'b1, tx1);
    chk1("uart2_rx", 1'b0, uart2_rx);
    host.wr_reg(8'h0C, 8'h03);
    repeat (4) @(negedge clk);
    chk1("ir_transmit_first", 1'b0, tx1);
    chk1("uart2_rx", 1'b1, uart2_rx);
    // Half duplex while transmitting: receive held idle
    host.wr_reg(8'h0C, 8'h04);
    repeat (4) @(negedge clk);
    chk1("uart2_rx", 1'b1, uart2_rx);
    host.wr_reg(8'h0C, 8'h00);
    host.wr_reg(8'h0A, 8'h40);
    uart2_tx = 1'b0;
    ir_rx1 = 1'b1;
    ir_rx2 = 1'b0;
    repeat (4) @(negedge clk);
    chk1("uart2_rx", 1'b0, uart2_rx);
    chk1("ir_transmit_second", 1'b0, tx2);
    host.wr_reg(8'h0A, 8'hC0);
    host.wr_reg(8'h0C, 8'hFF);
    do_reset();
    host.rd_reg(8'h0A, rd);
    chk8("mux after reset", 8'h00, rd);
    chk1("first_oe_n", 1'b0, tx1_oe_n);
    host.rd_reg(8'h0C, rd);
    chk8("serial after reset", 8'h02, rd);
    close_out();
  end
endmodule
